//--- core/psd_strap_decoder.sv
// Contract
// - Seven strap inputs each decode into a three-bit code.
// - Code by tie: supply 111, LED outputs 110 down to 001, ground 000.
// - Strap zero code gives management address bits two to zero.
// - Strap one gives pause enable and management address bits four and three.
// - Strap two at 111 enables auto-negotiation advertising all capabilities.
// - Strap three at 000 disables crossover and the 125 MHz clock output.
// - Strap five at 101 disables fibre/copper autoselect and enables sleep.
// - Strap six at 010 enables energy detect and supplies config mode top bit.
// - Config mode is strap six bit over strap four; 1011 selects RGMII copper.
`include "psd_strap_map.svh"
`default_nettype none
module psd_strap_decoder
  import psd_pkg::*;
(
  input  wire logic                        core_clk_in,
  input  wire logic                        reset_in,
  input  wire logic                        phy_hw_reset_n_in,
  input  wire logic [`PSD_NUM_STRAPS-1:0]  strap_level_in,
  input  wire logic                        link_ten_in,
  input  wire logic                        link_hundred_in,
  input  wire logic                        link_gigabit_in,
  input  wire logic                        state_a_in,
  input  wire logic                        receive_activity_in,
  input  wire logic                        transmit_activity_in,
  output logic                             led_link_ten_out,
  output logic                             led_link_hundred_out,
  output logic                             led_link_gigabit_out,
  output logic                             state_a_out,
  output logic                             led_receive_activity_out,
  output logic                             led_transmit_activity_out,
  output logic                             config_valid_out,
  output logic [4:0]                       mgmt_addr_out,
  output logic                             pause_en_out,
  output logic                             autoneg_en_out,
  output logic                             advertise_all_out,
  output logic [2:0]                       autoneg_pref_out,
  output logic                             crossover_en_out,
  output logic                             clock_out_125_en_out,
  output logic                             fibre_autosel_en_out,
  output logic                             sleep_en_out,
  output logic                             energy_detect_en_out,
  output logic [3:0]                       hw_config_select_out,
  output logic                             rgmii_copper_out
);
  localparam logic [7:0] SETTLE = 8'(`PSD_SETTLE_CYCLES);

  // ==========================================================
  // Own codes of the LED pins, shown one bit per scan phase
  localparam logic [2:0] TEN_CODE   = `PSD_CODE_LINK_TEN;
  localparam logic [2:0] HUND_CODE  = `PSD_CODE_LINK_HUND;
  localparam logic [2:0] GIG_CODE   = `PSD_CODE_LINK_GIG;
  localparam logic [2:0] STATE_CODE = `PSD_CODE_STATE_A;
  localparam logic [2:0] RX_CODE    = `PSD_CODE_RX_ACT;
  localparam logic [2:0] TX_CODE    = `PSD_CODE_TX_ACT;

  psd_state_e state_q;
  logic [1:0] phase_q;
  logic [7:0] settle_q;
  psd_code_t  code_q [`PSD_NUM_STRAPS];
  logic       hw_n_q;
  logic [4:0] mgmt_addr_d;
  logic       pause_en_d;
  logic       autoneg_en_d;
  logic       advertise_all_d;
  logic [2:0] autoneg_pref_d;
  logic       crossover_en_d;
  logic       clock_out_125_en_d;
  logic       fibre_autosel_en_d;
  logic       sleep_en_d;
  logic       energy_detect_en_d;
  logic [3:0] hw_config_select_d;
  logic       rgmii_copper_d;

  // ==========================================================
  // Sequencer: hold in reset, scan three phases, then run
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      state_q  <= PSD_ST_HOLD;
      phase_q  <= 2'h0;
      settle_q <= 8'h00;
      hw_n_q   <= 1'b0;
    end
    else
    begin
      hw_n_q <= phy_hw_reset_n_in;
      if (!phy_hw_reset_n_in)
      begin
        state_q  <= PSD_ST_HOLD;
        phase_q  <= 2'h0;
        settle_q <= 8'h00;
      end
      else
      begin
        unique case (state_q)
          PSD_ST_HOLD:
          begin
            if (!hw_n_q)
              state_q <= PSD_ST_SCAN;
          end
          PSD_ST_SCAN:
          begin
            if (settle_q == SETTLE - 8'h01)
            begin
              settle_q <= 8'h00;
              if (phase_q == `PSD_LAST_PHASE)
                state_q <= PSD_ST_RUN;
              else
                phase_q <= phase_q + 2'h1;
            end
            else
              settle_q <= settle_q + 8'h01;
          end
          PSD_ST_RUN:
          begin
            state_q <= PSD_ST_RUN;
          end
          default:
          begin
            state_q <= PSD_ST_HOLD;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Code capture: one bit per phase at the end of settling
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < `PSD_NUM_STRAPS; i++)
        code_q[i] <= 3'h0;
    end
    else if (state_q == PSD_ST_SCAN && settle_q == SETTLE - 8'h01)
    begin
      for (int i = 0; i < `PSD_NUM_STRAPS; i++)
        code_q[i][phase_q] <= strap_level_in[i];
    end
  end

  // ==========================================================
  // LED pins: code bit pattern while not running, status after
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      led_link_ten_out          <= 1'b0;
      led_link_hundred_out      <= 1'b0;
      led_link_gigabit_out      <= 1'b0;
      state_a_out               <= 1'b0;
      led_receive_activity_out  <= 1'b0;
      led_transmit_activity_out <= 1'b0;
    end
    else if (state_q == PSD_ST_RUN && phy_hw_reset_n_in)
    begin
      led_link_ten_out          <= link_ten_in;
      led_link_hundred_out      <= link_hundred_in;
      led_link_gigabit_out      <= link_gigabit_in;
      state_a_out               <= state_a_in;
      led_receive_activity_out  <= receive_activity_in;
      led_transmit_activity_out <= transmit_activity_in;
    end
    else
    begin
      led_link_ten_out          <= TEN_CODE[phase_q];
      led_link_hundred_out      <= HUND_CODE[phase_q];
      led_link_gigabit_out      <= GIG_CODE[phase_q];
      state_a_out               <= STATE_CODE[phase_q];
      led_receive_activity_out  <= RX_CODE[phase_q];
      led_transmit_activity_out <= TX_CODE[phase_q];
    end
  end

  // ==========================================================
  // Decoded defaults from the latched codes
  always_comb
  begin
    mgmt_addr_d        = {code_q[1][1:0], code_q[0]};
    pause_en_d         = code_q[1][`PSD_PAUSE_BIT];
    autoneg_en_d       = code_q[2] == `PSD_AUTONEG_ALL;
    advertise_all_d    = code_q[2] == `PSD_AUTONEG_ALL;
    autoneg_pref_d     = code_q[2];
    crossover_en_d     = code_q[3] != `PSD_XOVER_OFF;
    clock_out_125_en_d = code_q[3] != `PSD_XOVER_OFF;
    fibre_autosel_en_d = code_q[5] != `PSD_SLEEP_CODE;
    sleep_en_d         = code_q[5] == `PSD_SLEEP_CODE;
    energy_detect_en_d = code_q[6] == `PSD_ENERGY_CODE;
    hw_config_select_d = {code_q[6][`PSD_HWCFG_TOP_BIT], code_q[4]};
    rgmii_copper_d     = hw_config_select_d == `PSD_HWCFG_RGMII_CU;
  end

  // ==========================================================
  // Decoded defaults, loaded once when the scan completes
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || !phy_hw_reset_n_in)
    begin
      config_valid_out     <= 1'b0;
      mgmt_addr_out        <= 5'h00;
      pause_en_out         <= 1'b0;
      autoneg_en_out       <= 1'b0;
      advertise_all_out    <= 1'b0;
      autoneg_pref_out     <= 3'h0;
      crossover_en_out     <= 1'b0;
      clock_out_125_en_out <= 1'b0;
      fibre_autosel_en_out <= 1'b0;
      sleep_en_out         <= 1'b0;
      energy_detect_en_out <= 1'b0;
      hw_config_select_out <= 4'h0;
      rgmii_copper_out     <= 1'b0;
    end
    else if (state_q == PSD_ST_RUN && !config_valid_out)
    begin
      config_valid_out     <= 1'b1;
      mgmt_addr_out        <= mgmt_addr_d;
      pause_en_out         <= pause_en_d;
      autoneg_en_out       <= autoneg_en_d;
      advertise_all_out    <= advertise_all_d;
      autoneg_pref_out     <= autoneg_pref_d;
      crossover_en_out     <= crossover_en_d;
      clock_out_125_en_out <= clock_out_125_en_d;
      fibre_autosel_en_out <= fibre_autosel_en_d;
      sleep_en_out         <= sleep_en_d;
      energy_detect_en_out <= energy_detect_en_d;
      hw_config_select_out <= hw_config_select_d;
      rgmii_copper_out     <= rgmii_copper_d;
    end
  end
endmodule : psd_strap_decoder
`default_nettype wire

//--- core/psd_strap_map.svh
`ifndef PSD_STRAP_MAP_SVH
`define PSD_STRAP_MAP_SVH
// ==========================================================
// Strap count and level codes
`define PSD_NUM_STRAPS      7
`define PSD_CODE_IO_SUPPLY  3'h7
`define PSD_CODE_LINK_TEN   3'h6
`define PSD_CODE_LINK_HUND  3'h5
`define PSD_CODE_LINK_GIG   3'h4
`define PSD_CODE_STATE_A    3'h3
`define PSD_CODE_RX_ACT     3'h2
`define PSD_CODE_TX_ACT     3'h1
`define PSD_CODE_GROUND     3'h0
// ==========================================================
// Decoded setting codes
`define PSD_AUTONEG_ALL     3'h7
`define PSD_XOVER_OFF       3'h0
`define PSD_SLEEP_CODE      3'h5
`define PSD_ENERGY_CODE     3'h2
`define PSD_HWCFG_RGMII_CU  4'hB
// ==========================================================
// Field positions
`define PSD_PAUSE_BIT       2
`define PSD_HWCFG_TOP_BIT   1
// ==========================================================
// Timing
`define PSD_CLK_PERIOD_NS   10
`define PSD_SETTLE_NS       100
`define PSD_SETTLE_CYCLES   ((`PSD_SETTLE_NS + `PSD_CLK_PERIOD_NS - 1) / `PSD_CLK_PERIOD_NS)
`define PSD_LAST_PHASE      2'h2
`endif

//--- core/psd_pkg.sv
`default_nettype none
package psd_pkg;
  typedef enum logic [1:0] {
    PSD_ST_HOLD = 2'b00,
    PSD_ST_SCAN = 2'b01,
    PSD_ST_RUN  = 2'b10
  } psd_state_e;
  typedef logic [2:0] psd_code_t;
endpackage : psd_pkg
`default_nettype wire

//--- test/psd_strap_board.sv
`default_nettype none
module psd_strap_board (
  input  wire logic [20:0] tie_sel_in,
  input  wire logic [5:0]  led_in,
  output logic      [6:0]  strap_level_out
);
  always_comb
    for (int i = 0; i < 7; i++)
      case (tie_sel_in[3*i +: 3])
        3'h0, 3'h7: strap_level_out[i] = tie_sel_in[3*i];
        default:    strap_level_out[i] = led_in[tie_sel_in[3*i +: 3] - 3'h1];
      endcase
endmodule : psd_strap_board
`default_nettype wire

//--- test/psd_strap_decoder_properties.sv
`default_nettype none
module psd_strap_checker (
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  input wire logic       phy_hw_reset_n_in,
  input wire logic       led_link_hundred_out,
  input wire logic       config_valid_out,
  input wire logic [4:0] mgmt_addr_out,
  input wire logic       autoneg_en_out,
  input wire logic [2:0] autoneg_pref_out,
  input wire logic [3:0] hw_config_select_out,
  input wire logic       rgmii_copper_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in || !phy_hw_reset_n_in);
  sequence s_scan_go; $rose(phy_hw_reset_n_in); endsequence
  sequence s_wait_scan; !config_valid_out [*8] ##[23:25] config_valid_out; endsequence
  a_scan_latency: assert property (s_scan_go |-> s_wait_scan)
    else $error("late defaults");
  a_led_phase: assert property (s_scan_go |=> led_link_hundred_out [*8])
    else $error("bad scan pattern");
  a_hold_clear: assert property (s_scan_go |-> !config_valid_out && mgmt_addr_out == 5'h00)
    else $error("not cleared");
  a_cfg_frozen: assert property (config_valid_out ##1 config_valid_out |->
    $stable(mgmt_addr_out) && $stable(hw_config_select_out)) else $error("moved");
  a_valid_stands: assert property (config_valid_out |=> config_valid_out)
    else $error("valid dropped");
  a_valid_after: assert property ($rose(config_valid_out) |->
    $past(phy_hw_reset_n_in, 30)) else $error("no scan");
  a_autoneg_all: assert property (config_valid_out && autoneg_pref_out == 3'h7 |->
    autoneg_en_out) else $error("autoneg off");
  a_rgmii_mode: assert property (config_valid_out |->
    rgmii_copper_out == (hw_config_select_out == 4'hB)) else $error("mode flag");
endmodule : psd_strap_checker
bind psd_strap_decoder psd_strap_checker i_psd_strap_checker (.core_clk_in, .reset_in,
  .phy_hw_reset_n_in, .led_link_hundred_out, .config_valid_out, .mgmt_addr_out,
  .autoneg_en_out, .autoneg_pref_out, .hw_config_select_out, .rgmii_copper_out);
`default_nettype wire

//--- test/psd_strap_decoder_tb_top.sv
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t: %h vs %h", $time, a, b); end end
module psd_strap_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, hw_n = 1'b0, vld, pau, an, adv, xo, ck, fib, slp, en, rg;
  logic [20:0] sel = '0;
  logic [6:0]  strap;
  logic [5:0]  st = 6'h2A, led;
  logic [4:0]  addr;
  logic [3:0]  cfg;
  logic [2:0]  pref, c;
  int          num_errors = 0, num_checks = 0, cycles = 0;
  always #5 clk = ~clk;
  psd_strap_decoder i_psd_strap_decoder (.core_clk_in(clk), .reset_in(rst),
    .phy_hw_reset_n_in(hw_n), .strap_level_in(strap), .link_ten_in(st[5]),
    .link_hundred_in(st[4]), .link_gigabit_in(st[3]), .state_a_in(st[2]),
    .receive_activity_in(st[1]), .transmit_activity_in(st[0]), .led_link_ten_out(led[5]),
    .led_link_hundred_out(led[4]), .led_link_gigabit_out(led[3]), .state_a_out(led[2]),
    .led_receive_activity_out(led[1]), .led_transmit_activity_out(led[0]),
    .config_valid_out(vld), .mgmt_addr_out(addr), .pause_en_out(pau), .autoneg_en_out(an),
    .advertise_all_out(adv), .autoneg_pref_out(pref), .crossover_en_out(xo),
    .clock_out_125_en_out(ck), .fibre_autosel_en_out(fib), .sleep_en_out(slp),
    .energy_detect_en_out(en), .hw_config_select_out(cfg), .rgmii_copper_out(rg));
  psd_strap_board i_psd_strap_board (.tie_sel_in(sel), .led_in(led), .strap_level_out(strap));
  always @(posedge clk)
    if (++cycles == 1500)
      final_report(1);
  task automatic final_report(input int extra);
    num_errors += extra;
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic scan(input logic [20:0] s);
    sel = s;
    hw_n = 1'b0;
    @(negedge clk);
    hw_n = 1'b1;
    for (int n = 0; n < 50 && vld !== 1'b1; n++) @(negedge clk);
    `CHK(vld, 1'b1)
  endtask : scan
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK(led, 6'h15)
    scan({3'h2, 3'h5, 3'h3, 3'h0, 3'h7, 3'h0, 3'h0});
    `CHK({addr, pau, an, adv, pref}, 11'h01F)
    `CHK({xo, ck, fib, slp, en, cfg, rg}, 10'h077)
    sel = {7{3'h7}};
    st = 6'h33;
    repeat (40) @(negedge clk);
    `CHK({vld, addr, cfg}, 10'h20B)
    `CHK(led, 6'h33)
    for (int k = 0; k < 8; k++)
    begin
      c = 3'(k);
      scan({12'h3CC, c, ~c, c});
      `CHK({addr, pau, pref}, {~c[1:0], c, ~c[2], c})
      `CHK({xo, ck, fib, en, cfg, rg}, 9'h1C2)
    end
    final_report(0);
  end
endmodule : psd_strap_decoder_tb_top
`default_nettype wire
